// ==== ces_defs.vh ====
// Constants for the charger emulation sequencer
`ifndef CES_DEFS_VH
`define CES_DEFS_VH

// Profile codes
`define CES_PROF_W        4
`define CES_PROF_L1       4'h1
`define CES_PROF_L2       4'h2
`define CES_PROF_L3       4'h3
`define CES_PROF_L4       4'h4
`define CES_PROF_L5       4'h5
`define CES_PROF_L6       4'h6
`define CES_PROF_L7       4'h7
`define CES_PROF_CDP      4'h8
`define CES_PROF_DCP      4'h9
`define CES_PROF_NONE     4'h0

// Data-line bias codes, one per line
`define CES_BIAS_W        3
`define CES_BIAS_OFF      3'h0
`define CES_BIAS_LVL_A    3'h1
`define CES_BIAS_LVL_B    3'h2
`define CES_BIAS_DIV_A    3'h3
`define CES_BIAS_DIV_B    3'h4
`define CES_BIAS_900MV    3'h5

// Timing, in milliseconds and microseconds, and derived cycle counts at 100 MHz
`define CES_CLK_KHZ       100000
`define CES_EM_RESET_MS   100
`define CES_EM_TIMEOUT_MS 1000
`define CES_SETTLE_US     10
`define CES_EM_RESET_CYC  (`CES_EM_RESET_MS * `CES_CLK_KHZ)
`define CES_EM_TOUT_CYC   (`CES_EM_TIMEOUT_MS * `CES_CLK_KHZ)
`define CES_SETTLE_CYC    (`CES_SETTLE_US * `CES_CLK_KHZ / 1000)
`define CES_CNT_W         32

`endif

// ==== ces_portable_dev.sv ====
// Model of a portable device that draws charge on one chosen profile
`timescale 1ns/1ps
module ces_portable_dev (
	input  wire       sys_clk_i,
	input  wire       vbus_i,    // VBUS applied by the port
	input  wire [3:0] profile_i, // Profile being presented
	input  wire [3:0] target_i,  // Accepted profile, zero for none
	input  wire [7:0] delay_i,   // VBUS cycles before drawing current
	output reg        charge_o   // Drawing charge current
);
	reg [7:0] vbus_cnt = 8'h00; // Cycles since VBUS came up
	initial charge_o = 1'b0;
	// No current without VBUS; slow devices wait delay_i cycles first
	always @(posedge sys_clk_i) begin
		vbus_cnt <= vbus_i ? vbus_cnt + {7'h0, vbus_cnt != 8'hff} : 8'h00;
		charge_o <= vbus_i && profile_i == target_i && target_i != 0 && vbus_cnt >= delay_i;
	end
endmodule // ces_portable_dev

// ==== ces_sequencer.v ====
// Charger emulation sequencer for the dedicated charger cycle
// Function
// - Eight built-in profiles: legacy 1-7, DCP
// - In-cycle DCP profile runs the timeout timer
// - DCP charge: flag, keep short, high-speed switch open, CC
// - DCP no charge: drop profile, advance next
// - Legacy 2: short resistor first, then VBUS
// - Legacy 2 charge: accept, keep short, CC
// - Legacy 2 no charge: remove short, reset, next
// - Legacy 1,3,4,6: bias D+, then D-, VBUS
// - Legacy 1,3,4,6 charge: keep biases, trip mode
// - Legacy 1,3-6 no charge: remove biases, reset, next
// - Legacy 5: both lines 900 mV, VBUS; trip
// - Legacy 7: D+ divider only, VBUS, trip
// - Legacy 7 no charge: remove D+, reset, next
// - Order: L1, DCP, L2 through L7
// - Reset: switch open, discharge, pulldowns, hold time
// - No profile charges: reset and restart while enabled
`timescale 1ns/1ps
`include "ces_defs.vh"

module ces_sequencer #(
	// Phase lengths in clock cycles
	parameter [31:0] EM_RESET_CYC = `CES_EM_RESET_CYC,
	parameter [31:0] EM_TOUT_CYC  = `CES_EM_TOUT_CYC,
	parameter [31:0] SETTLE_CYC   = `CES_SETTLE_CYC
) (
	input  wire                   sys_clk_i,
	input  wire                   rstn_i,
	// Control pins from outside the clock domain
	input  wire                   port_power_enable_i,
	input  wire                   charge_detected_i,
	// Power path
	output reg                    vbus_switch_closed_o,
	output reg                    vbus_discharge_o,
	output reg                    data_pulldown_o,
	// Data-line short and bias
	output reg                    data_line_short_resistor_o,
	output reg                    hs_switch_closed_o,
	output reg  [`CES_BIAS_W-1:0] positive_data_out_line_o,
	output reg  [`CES_BIAS_W-1:0] negative_data_out_line_o,
	// Current limit style and status
	output reg                    cc_limit_o,
	output reg                    trip_limit_o,
	output reg                    profile_locked_o,
	output reg                    dcp_detected_o,
	output reg  [`CES_PROF_W-1:0] active_profile_o
);

	// Sequencer states
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_RESET = 3'h1;
	localparam [2:0] ST_BIASP = 3'h2;
	localparam [2:0] ST_BIASM = 3'h3;
	localparam [2:0] ST_VBUS  = 3'h4;
	localparam [2:0] ST_EVAL  = 3'h5;
	localparam [2:0] ST_LOCK  = 3'h6;

	// Sequencer state, profile and phase timer
	reg [2:0]             state_reg;    // Current state
	reg [`CES_PROF_W-1:0] prof_reg;     // Profile being applied
	reg [`CES_CNT_W-1:0]  cnt_reg;      // Phase timer
	reg [2:0]             chg_sync_reg; // Charge input synchroniser
	reg                   chg_reg;      // Qualified charge level
	reg                   en_s1_reg;    // Enable synchroniser
	reg                   en_s2_reg;    // Second enable flop
	reg                   en_s3_reg;    // Third enable flop
	reg                   en_reg;       // Qualified enable level

	// Next profile in the fixed cycle order
	function [`CES_PROF_W-1:0] next_prof;
		input [`CES_PROF_W-1:0] p;
		begin
			case (p)
				`CES_PROF_L1:  next_prof = `CES_PROF_DCP;
				`CES_PROF_DCP: next_prof = `CES_PROF_L2;
				`CES_PROF_L2:  next_prof = `CES_PROF_L3;
				`CES_PROF_L3:  next_prof = `CES_PROF_L4;
				`CES_PROF_L4:  next_prof = `CES_PROF_L5;
				`CES_PROF_L5:  next_prof = `CES_PROF_L6;
				`CES_PROF_L6:  next_prof = `CES_PROF_L7;
				// Legacy 7 and unknown codes wrap to the first profile
				default:       next_prof = `CES_PROF_L1;
			endcase
		end
	endfunction

	// Positive-line bias per profile
	function [`CES_BIAS_W-1:0] bias_p;
		input [`CES_PROF_W-1:0] p;
		begin
			case (p)
				`CES_PROF_L1: bias_p = `CES_BIAS_LVL_A;
				`CES_PROF_L3: bias_p = `CES_BIAS_DIV_A;
				`CES_PROF_L4: bias_p = `CES_BIAS_DIV_B;
				`CES_PROF_L6: bias_p = `CES_BIAS_LVL_B;
				`CES_PROF_L5: bias_p = `CES_BIAS_900MV;
				`CES_PROF_L7: bias_p = `CES_BIAS_DIV_A;
				// Short-type profiles leave the plus line unbiased
				default:      bias_p = `CES_BIAS_OFF;
			endcase
		end
	endfunction

	// Negative-line bias per profile
	function [`CES_BIAS_W-1:0] bias_m;
		input [`CES_PROF_W-1:0] p;
		begin
			case (p)
				`CES_PROF_L1: bias_m = `CES_BIAS_LVL_B;
				`CES_PROF_L3: bias_m = `CES_BIAS_DIV_B;
				`CES_PROF_L4: bias_m = `CES_BIAS_DIV_A;
				`CES_PROF_L6: bias_m = `CES_BIAS_LVL_A;
				`CES_PROF_L5: bias_m = `CES_BIAS_900MV;
				// Legacy 7 and short-type profiles leave the minus line alone
				default:      bias_m = `CES_BIAS_OFF;
			endcase
		end
	endfunction

	// True for profiles that use the resistive short
	function uses_short;
		input [`CES_PROF_W-1:0] p;
		begin
			uses_short = (p == `CES_PROF_L2) || (p == `CES_PROF_DCP);
		end
	endfunction

	// Pin synchronisers: three flops, change counts when last two agree
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// Synchronisers clear to the idle level of the pins
			chg_sync_reg <= 3'h0;
			chg_reg      <= 1'b0;
			en_s1_reg    <= 1'b0;
			en_s2_reg    <= 1'b0;
			en_s3_reg    <= 1'b0;
			en_reg       <= 1'b0;
		end else begin
			// Shift both pins through their flop chains
			chg_sync_reg <= {chg_sync_reg[1:0], charge_detected_i};
			en_s1_reg    <= port_power_enable_i;
			en_s2_reg    <= en_s1_reg;
			en_s3_reg    <= en_s2_reg;
			// Qualified levels update only on agreement
			if (chg_sync_reg[1] == chg_sync_reg[2]) begin
				chg_reg <= chg_sync_reg[2];
			end
			// Enable qualifies the same way
			if (en_s2_reg == en_s3_reg) begin
				en_reg <= en_s3_reg;
			end
		end
	end

	// Sequencer state machine
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			prof_reg  <= `CES_PROF_NONE;
			cnt_reg   <= {`CES_CNT_W{1'b0}};
		end else if (!en_reg) begin
			// Enable low stops everything
			state_reg <= ST_IDLE;
			prof_reg  <= `CES_PROF_NONE;
			cnt_reg   <= {`CES_CNT_W{1'b0}};
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// Start the cycle from the first profile
					state_reg <= ST_RESET;
					prof_reg  <= `CES_PROF_L1;
					cnt_reg   <= {`CES_CNT_W{1'b0}};
				end
				ST_RESET: begin
					// Hold the emulation reset, then bias the lines
					if (cnt_reg >= EM_RESET_CYC - 32'h1) begin
						// Hold time done; the lines may now be biased
						cnt_reg   <= {`CES_CNT_W{1'b0}};
						state_reg <= ST_BIASP;
					end else begin
						// VBUS stays grounded meanwhile
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				ST_BIASP: begin
					// Positive line (or short) settles before the negative line
					if (cnt_reg >= SETTLE_CYC - 32'h1) begin
						// Plus line settled
						cnt_reg   <= {`CES_CNT_W{1'b0}};
						state_reg <= ST_BIASM;
					end else begin
						// Still settling
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				ST_BIASM: begin
					// Negative line settles before VBUS
					if (cnt_reg >= SETTLE_CYC - 32'h1) begin
						// Minus line settled; VBUS next
						cnt_reg   <= {`CES_CNT_W{1'b0}};
						state_reg <= ST_VBUS;
					end else begin
						// Still settling
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				ST_VBUS: begin
					// VBUS applied; evaluation window starts
					state_reg <= ST_EVAL;
					cnt_reg   <= {`CES_CNT_W{1'b0}};
				end
				ST_EVAL: begin
					// Timeout timer bounds every profile, DCP included,
					// unlike the standalone DCP mode where it never runs
					if (cnt_reg >= EM_TOUT_CYC - 32'h1) begin
						// Window over: judge the qualified charge level
						cnt_reg <= {`CES_CNT_W{1'b0}};
						if (chg_reg) begin
							// Device charging: lock this profile in
							state_reg <= ST_LOCK;
						end else begin
							// Tear down, reset and try the next one
							state_reg <= ST_RESET;
							prof_reg  <= next_prof(prof_reg);
						end
					end else begin
						// Window still open
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				ST_LOCK: begin
					// Profile accepted; hold while enabled
					state_reg <= ST_LOCK;
				end
				default: begin
					// Unused code: recover to idle
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Output registers decoded from state and profile
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vbus_switch_closed_o       <= 1'b0;
			vbus_discharge_o           <= 1'b0;
			data_pulldown_o            <= 1'b0;
			data_line_short_resistor_o <= 1'b0;
			hs_switch_closed_o         <= 1'b0;
			positive_data_out_line_o   <= `CES_BIAS_OFF;
			negative_data_out_line_o   <= `CES_BIAS_OFF;
			cc_limit_o                 <= 1'b0;
			trip_limit_o               <= 1'b0;
			profile_locked_o           <= 1'b0;
			dcp_detected_o             <= 1'b0;
			active_profile_o           <= `CES_PROF_NONE;
		end else begin
			// Switch opened during reset and idle; VBUS discharged during reset only
			vbus_switch_closed_o <= (state_reg == ST_VBUS) ||
				(state_reg == ST_EVAL) || (state_reg == ST_LOCK);
			vbus_discharge_o     <= (state_reg == ST_RESET);
			data_pulldown_o      <= (state_reg == ST_RESET) || (state_reg == ST_IDLE);
			// High-speed switch stays open in this cycle
			hs_switch_closed_o   <= 1'b0;
			// Short applied from the first bias phase
			data_line_short_resistor_o <= uses_short(prof_reg) &&
				(state_reg >= ST_BIASP) && (state_reg <= ST_LOCK);
			// Positive line from first bias phase, negative from second
			if ((state_reg >= ST_BIASP) && (state_reg <= ST_LOCK)) begin
				// Bias held through evaluation and lock
				positive_data_out_line_o <= bias_p(prof_reg);
			end else begin
				// Line unbiased in reset and idle
				positive_data_out_line_o <= `CES_BIAS_OFF;
			end
			if ((state_reg >= ST_BIASM) && (state_reg <= ST_LOCK)) begin
				// Bias held through evaluation and lock
				negative_data_out_line_o <= bias_m(prof_reg);
			end else begin
				// Line unbiased in reset, idle and the first bias phase
				negative_data_out_line_o <= `CES_BIAS_OFF;
			end
			// CC while applying or after short-type accept; trip for others
			if (state_reg == ST_LOCK) begin
				// Accepted: limit style fixed by profile type
				cc_limit_o   <= uses_short(prof_reg);
				trip_limit_o <= !uses_short(prof_reg);
			end else begin
				// Applying a profile: CC follows the switch
				cc_limit_o   <= vbus_switch_closed_o;
				trip_limit_o <= 1'b0;
			end
			// Status outputs trail the state by one cycle
			profile_locked_o <= (state_reg == ST_LOCK);
			// Internal flag for an accepted DCP profile
			dcp_detected_o   <= (state_reg == ST_LOCK) && (prof_reg == `CES_PROF_DCP);
			active_profile_o <= prof_reg;
		end
	end

endmodule // ces_sequencer

// ==== ces_sequencer_asserts.sv ====
// Port assertions for the charger emulation sequencer
`timescale 1ns/1ps
`include "ces_defs.vh"
module ces_seq_asserts (
	input logic                   sys_clk_i,
	input logic                   rstn_i,
	input logic                   port_power_enable_i,
	input logic                   charge_detected_i,
	input logic                   vbus_switch_closed_o,
	input logic                   vbus_discharge_o,
	input logic                   data_pulldown_o,
	input logic                   data_line_short_resistor_o,
	input logic                   hs_switch_closed_o,
	input logic [`CES_BIAS_W-1:0] positive_data_out_line_o,
	input logic [`CES_BIAS_W-1:0] negative_data_out_line_o,
	input logic                   cc_limit_o,
	input logic                   trip_limit_o,
	input logic                   profile_locked_o,
	input logic                   dcp_detected_o,
	input logic [`CES_PROF_W-1:0] active_profile_o
);
	// Profile that follows p in the cycle
	function automatic [3:0] ces_nxt(input [3:0] p);
		case (p)
			4'h1: ces_nxt = 4'h9;
			4'h9: ces_nxt = 4'h2;
			4'h7: ces_nxt = 4'h1;
			default: ces_nxt = p + 4'h1;
		endcase
	endfunction
	wire l2dcp = active_profile_o == `CES_PROF_L2 || active_profile_o == `CES_PROF_DCP;
	wire pon   = positive_data_out_line_o != `CES_BIAS_OFF; // Plus line biased
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	chk_hs_sw_open: assert property (!hs_switch_closed_o)
		else $error("high-speed switch closed");
	chk_reset_state: assert property (vbus_discharge_o |-> !vbus_switch_closed_o &&
		data_pulldown_o && !pon && negative_data_out_line_o == `CES_BIAS_OFF)
		else $error("emulation reset state wrong");
	chk_reset_hold: assert property ($rose(vbus_discharge_o) |-> vbus_discharge_o[*8])
		else $error("discharge too short");
	chk_cc_lock: assert property (profile_locked_o && l2dcp |-> cc_limit_o && !trip_limit_o
		&& data_line_short_resistor_o && vbus_switch_closed_o)
		else $error("short profile lock wrong");
	chk_trip_lock: assert property (profile_locked_o && !l2dcp |-> trip_limit_o && !cc_limit_o)
		else $error("trip lock wrong");
	chk_dcp_flag: assert property (dcp_detected_o == (profile_locked_o && active_profile_o == 4'h9))
		else $error("dcp flag wrong");
	chk_prof_order: assert property ($changed(active_profile_o) && $past(active_profile_o) != 0
		&& active_profile_o != 0 |-> active_profile_o == ces_nxt($past(active_profile_o)))
		else $error("profile order wrong");
	chk_short_first: assert property ($rose(vbus_switch_closed_o) && active_profile_o == 4'h2
		|-> $past(data_line_short_resistor_o))
		else $error("vbus before short");
	chk_l5_level: assert property (active_profile_o == 4'h5 && vbus_switch_closed_o |->
		positive_data_out_line_o == `CES_BIAS_900MV && negative_data_out_line_o == `CES_BIAS_900MV)
		else $error("level five bias wrong");
	chk_l7_plus: assert property (active_profile_o == 4'h7 && vbus_switch_closed_o |-> pon &&
		negative_data_out_line_o == `CES_BIAS_OFF)
		else $error("level seven bias wrong");
	chk_plus_first: assert property ($rose(negative_data_out_line_o != 0) &&
		active_profile_o != 4'h5 |-> $past(pon))
		else $error("minus before plus");
	cover property (dcp_detected_o);
	cover property ($rose(profile_locked_o) && trip_limit_o);
	cover property ($rose(vbus_discharge_o) && active_profile_o == 4'h1);
endmodule // ces_seq_asserts

bind ces_sequencer ces_seq_asserts u_chk (
	.sys_clk_i                  (sys_clk_i),
	.rstn_i                     (rstn_i),
	.port_power_enable_i        (port_power_enable_i),
	.charge_detected_i          (charge_detected_i),
	.vbus_switch_closed_o       (vbus_switch_closed_o),
	.vbus_discharge_o           (vbus_discharge_o),
	.data_pulldown_o            (data_pulldown_o),
	.data_line_short_resistor_o (data_line_short_resistor_o),
	.hs_switch_closed_o         (hs_switch_closed_o),
	.positive_data_out_line_o   (positive_data_out_line_o),
	.negative_data_out_line_o   (negative_data_out_line_o),
	.cc_limit_o                 (cc_limit_o),
	.trip_limit_o               (trip_limit_o),
	.profile_locked_o           (profile_locked_o),
	.dcp_detected_o             (dcp_detected_o),
	.active_profile_o           (active_profile_o)
);

// ==== charger_emulation_sequencer_test.sv ====
// Self-checking testbench for the charger emulation sequencer
`timescale 1ns/1ps
`include "ces_defs.vh"
module charger_emulation_sequencer_test;
	localparam [31:0] ORD = 32'h76543291; // Cycle order, one nibble per step
	reg        sys_clk_i = 1'b0;
	reg        rstn_i = 1'b0;
	reg        port_power_enable_i = 1'b0;
	reg  [3:0] target = 4'h0;  // Profile the device accepts
	reg  [7:0] delay = 8'h00;  // Device response delay
	integer    errors = 0;
	integer    check_count = 0;
	integer    cycles = 0;
	integer    k;
	wire       charge, vsw, vdis, pd, shrt, hs, cc, trip, lock, dcp;
	wire [2:0] pos, neg;
	wire [3:0] prof;
	wire [9:0] lock_st = {prof, lock, vsw, cc, trip, shrt, dcp}; // Lock outcome
	ces_sequencer #(.EM_RESET_CYC(32'd20), .EM_TOUT_CYC(32'd50), .SETTLE_CYC(32'd4)) dut (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .port_power_enable_i(port_power_enable_i),
		.charge_detected_i(charge), .vbus_switch_closed_o(vsw), .vbus_discharge_o(vdis),
		.data_pulldown_o(pd), .data_line_short_resistor_o(shrt), .hs_switch_closed_o(hs),
		.positive_data_out_line_o(pos), .negative_data_out_line_o(neg), .cc_limit_o(cc),
		.trip_limit_o(trip), .profile_locked_o(lock), .dcp_detected_o(dcp),
		.active_profile_o(prof));
	ces_portable_dev u_dev (.sys_clk_i(sys_clk_i), .vbus_i(vsw), .profile_i(prof),
		.target_i(target), .delay_i(delay), .charge_o(charge));
	// Clock at 100 MHz
	initial forever #5 sys_clk_i = ~sys_clk_i;
	// Compare and count
	task check(input [9:0] seen, input [9:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	// Print counts and verdict
	task results;
		begin
			$display("Checks %0d, errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Device accepts profile p; expect lock, limit style, then all off
	task test_lock(input [3:0] p, input [7:0] d);
		reg c;
		integer n;
		begin
			c = p == `CES_PROF_L2 || p == `CES_PROF_DCP;
			target = p;
			delay = d;
			port_power_enable_i = 1'b1;
			for (n = 0; n < 1000 && lock !== 1'b1; n = n + 1)
				@(negedge sys_clk_i);
			check(lock_st, {p, 2'b11, c, ~c, c, p == `CES_PROF_DCP});
			check({5'h0, vdis, pd, hs, |pos, |neg}, {8'h0, ~c, ~c && p != `CES_PROF_L7});
			repeat (80) @(negedge sys_clk_i);
			check(lock_st, {p, 2'b11, c, ~c, c, p == `CES_PROF_DCP});
			port_power_enable_i = 1'b0;
			repeat (10) @(negedge sys_clk_i);
			check(lock_st, 10'h0);
			$display("Lock test on profile %0d done", p);
		end
	endtask
	// Device answers too late; the port must cycle and wrap without locking
	task test_retry;
		reg [3:0] prev;
		integer n, s;
		begin
			target = `CES_PROF_L1;
			delay = 8'd60;
			prev = 4'h0;
			s = 0;
			port_power_enable_i = 1'b1;
			for (n = 0; n < 2000 && s < 9; n = n + 1) begin
				@(negedge sys_clk_i);
				if (prof !== prev) begin
					check({6'h0, prof}, {6'h0, ORD[4 * (s % 8) +: 4]});
					check({4'h0, vdis, pd, vsw, shrt, |pos, |neg}, 10'h030);
					prev = prof;
					s = s + 1;
				end
				if (lock !== 1'b0)
					check({9'h0, lock}, 10'h0);
			end
			check(s[9:0], 10'd9);
			rstn_i = 1'b0;
			@(negedge sys_clk_i);
			check(lock_st, 10'h0);
			rstn_i = 1'b1;
			port_power_enable_i = 1'b0;
			$display("Retry test done");
		end
	endtask
	// Hang guard
	always @(posedge sys_clk_i) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results;
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		for (k = 0; k < 8; k = k + 1)
			test_lock(ORD[4 * k +: 4], k[0] ? 8'd30 : 8'd0);
		test_retry;
		results;
	end
endmodule // charger_emulation_sequencer_test
